// >>> src/link_gpio_and_backchannel_ctrl.sv
// link gpio, register-only gpio, back channel rate and remote interrupt forwarding
//=====================================================================
`timescale 1ns/1ps
`include "link_gpio_defines.svh"
module link_gpio_and_backchannel_ctrl #(
  parameter int NGPIO = 4,
  parameter int NREG = 4
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire link_gpio_pkg::reg_req_s REQ,
  output logic [7:0] RDATA,
  output logic RVALID,
  input wire logic TWO_LANE,
  input wire logic STRAP_HS,
  input wire logic MODE18_LOAD,
  input wire logic MODE18_VALUE,
  output logic MODE18,
  input wire logic REMOTE_INTERRUPT_INPUT_N,
  output logic BC_INTR,
  input wire logic [NGPIO-1:0] FWD_GPIO,
  input wire logic [NGPIO-1:0] FWD_D_GPIO,
  input wire logic [NGPIO-1:0] GPIO_I,
  output logic [NGPIO-1:0] GPIO_O,
  output logic [NGPIO-1:0] GPIO_OE,
  input wire logic [NGPIO-1:0] D_GPIO_I,
  output logic [NGPIO-1:0] D_GPIO_O,
  output logic [NGPIO-1:0] D_GPIO_OE,
  input wire logic [NREG-1:0] REG_GPIO_I,
  output logic [NREG-1:0] REG_GPIO_O,
  output logic [NREG-1:0] REG_GPIO_OE,
  output logic [NREG-1:0] AUDIO_IN_BLOCK,
  output link_gpio_pkg::bc_sample_s BC_SAMPLE,
  output logic [2:0] BC_DIVIDER,
  output link_gpio_pkg::bc_rate_e BC_RATE
);
  logic [15:0] cfg_q [2];
  logic [15:0] reg_cfg_q;
  logic [7:0] bc_rate_q;
  logic [1:0] port_sel_q;
  logic [7:0] cc_cfg_q;
  logic strap_seen_q;
  logic [NGPIO-1:0] g_s1_q, g_s2_q, d_s1_q, d_s2_q;
  logic [NREG-1:0] r_s1_q, r_s2_q;
  logic int_s1_q, int_s2_q, int_prev_q;
  link_gpio_pkg::int_state_e int_q;
  logic [3:0] samp_cnt_q;
  logic [3:0] samp_target;
  logic [3:0] gpio_in_sel;
  logic wr_port0, wr_port1;
  logic [3:0] reg_code [NREG];
  //=====================================================================
  // input synchronisers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      g_s1_q <= '0;
      g_s2_q <= '0;
      d_s1_q <= '0;
      d_s2_q <= '0;
      r_s1_q <= '0;
      r_s2_q <= '0;
      int_s1_q <= 1'b1;
      int_s2_q <= 1'b1;
    end else begin
      g_s1_q <= GPIO_I;
      g_s2_q <= g_s1_q;
      d_s1_q <= D_GPIO_I;
      d_s2_q <= d_s1_q;
      r_s1_q <= REG_GPIO_I;
      r_s2_q <= r_s1_q;
      int_s1_q <= REMOTE_INTERRUPT_INPUT_N;
      int_s2_q <= int_s1_q;
    end
  end
  //=====================================================================
  // register writes
  // the duplicated port-0/port-1 gpio bank
  assign wr_port0 = REQ.we && port_sel_q[0];
  assign wr_port1 = REQ.we && port_sel_q[1];
  always_ff @(posedge CLK) begin
    if (SRST) begin
      cfg_q[0] <= {2{`CFG_RESET}};
      cfg_q[1] <= {2{`CFG_RESET}};
    end else begin
      if (wr_port0 && REQ.addr == `ADDR_GPIO0_CFG) cfg_q[0][3:0] <= REQ.wdata[3:0];
      if (wr_port0 && REQ.addr == `ADDR_GPIO12_CFG) cfg_q[0][11:4] <= REQ.wdata;
      if (wr_port0 && REQ.addr == `ADDR_GPIO3_CFG) cfg_q[0][15:12] <= REQ.wdata[3:0];
      if (wr_port1 && REQ.addr == `ADDR_GPIO0_CFG) cfg_q[1][3:0] <= REQ.wdata[3:0];
      if (wr_port1 && REQ.addr == `ADDR_GPIO12_CFG) cfg_q[1][11:4] <= REQ.wdata;
      if (wr_port1 && REQ.addr == `ADDR_GPIO3_CFG) cfg_q[1][15:12] <= REQ.wdata[3:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      reg_cfg_q <= {2{`CFG_RESET}};
      cc_cfg_q <= `CC_CFG_RESET;
      port_sel_q <= 2'(`PORT_SEL_RESET);
    end else if (REQ.we) begin
      if (REQ.addr == `ADDR_REG56_CFG) reg_cfg_q[7:0] <= REQ.wdata;
      if (REQ.addr == `ADDR_REG78_CFG) reg_cfg_q[15:8] <= REQ.wdata;
      if (REQ.addr == `ADDR_CC_CFG) cc_cfg_q <= REQ.wdata;
      if (REQ.addr == `ADDR_PORT_SEL) port_sel_q <= REQ.wdata[1:0];
    end
  end
  // strap caught once after reset release, then software owns the bit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      bc_rate_q <= `BC_RATE_RESET;
      strap_seen_q <= 1'b0;
    end else if (!strap_seen_q) begin
      strap_seen_q <= 1'b1;
      bc_rate_q[`BIT_BC_HS_EN] <= STRAP_HS;
    end else if (REQ.we && REQ.addr == `ADDR_BC_RATE) begin
      bc_rate_q <= REQ.wdata;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) MODE18 <= 1'b0;
    else if (MODE18_LOAD) MODE18 <= MODE18_VALUE;
  end
  //=====================================================================
  // register reads
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      gpio_in_sel[i] = g_s2_q[i];
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
      RVALID <= 1'b0;
    end else begin
      RVALID <= REQ.re;
      RDATA <= 8'h00;
      if (REQ.re) begin
        unique case (REQ.addr)
          `ADDR_GPIO0_CFG: RDATA <= {4'h0, cfg_q[port_sel_q[1]][3:0]};
          `ADDR_GPIO12_CFG: RDATA <= cfg_q[port_sel_q[1]][11:4];
          `ADDR_GPIO3_CFG: RDATA <= {4'h0, cfg_q[port_sel_q[1]][15:12]};
          `ADDR_REG56_CFG: RDATA <= reg_cfg_q[7:0];
          `ADDR_REG78_CFG: RDATA <= reg_cfg_q[15:8];
          `ADDR_BC_RATE: RDATA <= bc_rate_q;
          `ADDR_PORT_SEL: RDATA <= {6'h00, port_sel_q};
          `ADDR_CC_CFG: RDATA <= cc_cfg_q;
          `ADDR_IN_STAT_LO: RDATA <= {r_s2_q[2:0], 1'b0, port_sel_q[1] ? d_s2_q : gpio_in_sel};
          `ADDR_IN_STAT_HI: RDATA <= {7'h00, r_s2_q[3]};
          default: RDATA <= 8'h00;
        endcase
      end
    end
  end
  //=====================================================================
  // pin drivers
  generate
    for (genvar i = 0; i < NGPIO; i++) begin : g_link
      logic [3:0] c0, c1;
      assign c0 = cfg_q[0][4*i+3:4*i];
      assign c1 = cfg_q[1][4*i+3:4*i];
      always_ff @(posedge CLK) begin
        if (SRST) begin
          GPIO_O[i] <= 1'b0;
          GPIO_OE[i] <= 1'b0;
          D_GPIO_O[i] <= 1'b0;
          D_GPIO_OE[i] <= 1'b0;
        end else begin
          GPIO_OE[i] <= (c0 == `CODE_FWD_OUT) || (c0 == `CODE_OUT_LOW) || (c0 == `CODE_OUT_HIGH);
          GPIO_O[i] <= (c0 == `CODE_FWD_OUT) ? FWD_GPIO[i] : (c0 == `CODE_OUT_HIGH);
          // secondary lane pins stay released on a single-lane link
          D_GPIO_OE[i] <= TWO_LANE && ((c1 == `CODE_FWD_OUT) || (c1 == `CODE_OUT_LOW) ||
                                       (c1 == `CODE_OUT_HIGH));
          D_GPIO_O[i] <= TWO_LANE && ((c1 == `CODE_FWD_OUT) ? FWD_D_GPIO[i] : (c1 == `CODE_OUT_HIGH));
        end
      end
    end
    for (genvar j = 0; j < NREG; j++) begin : g_reg
      assign reg_code[j] = reg_cfg_q[4*j+3:4*j];
      always_ff @(posedge CLK) begin
        if (SRST) begin
          REG_GPIO_O[j] <= 1'b0;
          REG_GPIO_OE[j] <= 1'b0;
          AUDIO_IN_BLOCK[j] <= 1'b0;
        end else begin
          REG_GPIO_OE[j] <= (reg_code[j] == `CODE_OUT_LOW) || (reg_code[j] == `CODE_OUT_HIGH);
          REG_GPIO_O[j] <= reg_code[j] == `CODE_OUT_HIGH;
          AUDIO_IN_BLOCK[j] <= reg_code[j] != 4'h0;
        end
      end
    end
  endgenerate
  //=====================================================================
  // back channel rate
  always_ff @(posedge CLK) begin
    if (SRST) begin
      BC_DIVIDER <= `DIV_SLOW;
      BC_RATE <= link_gpio_pkg::RATE_5M;
    end else begin
      if (bc_rate_q[`BIT_BC_HS_EN]) begin
        BC_DIVIDER <= `DIV_FAST;
        BC_RATE <= link_gpio_pkg::RATE_20M;
      end else if (bc_rate_q[`BIT_BC_DIV_SEL]) begin
        BC_DIVIDER <= `DIV_MID;
        BC_RATE <= link_gpio_pkg::RATE_10M;
      end else begin
        BC_DIVIDER <= `DIV_SLOW;
        BC_RATE <= link_gpio_pkg::RATE_5M;
      end
    end
  end
  //=====================================================================
  // back channel sampling
  always_comb begin
    unique case (cc_cfg_q[2:0])
      `MODE_FAST4: samp_target = `SAMPLES_FAST4;
      `MODE_FAST2: samp_target = `SAMPLES_FAST2;
      `MODE_FAST1: samp_target = `SAMPLES_FAST1;
      default: samp_target = `SAMPLES_NORMAL;
    endcase
  end
  // one sample per pulse; count says position within the frame
  always_ff @(posedge CLK) begin
    if (SRST) begin
      samp_cnt_q <= 4'h0;
      BC_SAMPLE <= '0;
    end else begin
      samp_cnt_q <= (samp_cnt_q + 4'h1 >= samp_target) ? 4'h0 : samp_cnt_q + 4'h1;
      BC_SAMPLE.valid <= 1'b1;
      BC_SAMPLE.count <= samp_cnt_q;
      BC_SAMPLE.intr_n <= int_s2_q;
      for (int k = 0; k < NGPIO; k++) begin
        BC_SAMPLE.gpio[k] <= (cfg_q[0][4*k+:4] == `CODE_INPUT) && g_s2_q[k];
      end
      if (cc_cfg_q[2:0] == `MODE_FAST2) BC_SAMPLE.gpio[3:2] <= 2'b00;
      if (cc_cfg_q[2:0] == `MODE_FAST1) BC_SAMPLE.gpio[3:1] <= 3'b000;
    end
  end
  //=====================================================================
  // remote interrupt forwarding
  always_ff @(posedge CLK) begin
    if (SRST) begin
      int_q <= link_gpio_pkg::INT_IDLE;
      int_prev_q <= 1'b1;
      BC_INTR <= 1'b0;
    end else begin
      int_prev_q <= int_s2_q;
      unique case (int_q)
        link_gpio_pkg::INT_IDLE: begin
          if (int_prev_q && !int_s2_q) begin
            int_q <= link_gpio_pkg::INT_SENT;
            BC_INTR <= 1'b1;
          end
        end
        link_gpio_pkg::INT_SENT: begin
          int_q <= link_gpio_pkg::INT_WAIT_RELEASE;
        end
        link_gpio_pkg::INT_WAIT_RELEASE: begin
          if (int_s2_q) begin
            int_q <= link_gpio_pkg::INT_IDLE;
            BC_INTR <= 1'b0;
          end
        end
        default: int_q <= link_gpio_pkg::INT_IDLE;
      endcase
    end
  end
  //=====================================================================
  // checks
  a_hs_forces_div: assert property (@(posedge CLK) disable iff (SRST)
    bc_rate_q[`BIT_BC_HS_EN] && $stable(bc_rate_q) |=> BC_DIVIDER == `DIV_FAST)
    else $error("high speed did not force divide by one");
  a_hs_rate: assert property (@(posedge CLK) disable iff (SRST)
    bc_rate_q[`BIT_BC_HS_EN] |=> BC_RATE == link_gpio_pkg::RATE_20M)
    else $error("high speed did not select the fast rate");
  a_strap_capture: assert property (@(posedge CLK) disable iff (SRST)
    $rose(strap_seen_q) |-> bc_rate_q[`BIT_BC_HS_EN] == $past(STRAP_HS))
    else $error("strap not captured into high speed bit");
  a_div_sel_rate: assert property (@(posedge CLK) disable iff (SRST)
    !bc_rate_q[`BIT_BC_HS_EN] && $stable(bc_rate_q) |=>
    BC_DIVIDER == ($past(bc_rate_q[`BIT_BC_DIV_SEL]) ? `DIV_MID : `DIV_SLOW))
    else $error("divider select wrong");
  a_int_forward: assert property (@(posedge CLK) disable iff (SRST)
    int_q == link_gpio_pkg::INT_IDLE && int_prev_q && !int_s2_q |=> BC_INTR)
    else $error("falling interrupt not forwarded");
  a_int_release: assert property (@(posedge CLK) disable iff (SRST)
    int_q == link_gpio_pkg::INT_WAIT_RELEASE && int_s2_q |=> !BC_INTR && int_q == link_gpio_pkg::INT_IDLE)
    else $error("interrupt not rearmed after release");
  // one cycle of grace while a mode change wraps the count
  a_sample_wrap: assert property (@(posedge CLK) disable iff (SRST)
    $stable(cc_cfg_q[2:0]) |-> samp_cnt_q < samp_target)
    else $error("sample count beyond frame");
  a_dgpio_single: assert property (@(posedge CLK) disable iff (SRST)
    !$past(TWO_LANE) |-> D_GPIO_OE == '0)
    else $error("secondary gpio driven on single lane");
  a_local_high: assert property (@(posedge CLK) disable iff (SRST)
    cfg_q[0][3:0] == `CODE_OUT_HIGH ##1 $stable(cfg_q[0][3:0]) |-> GPIO_OE[0] && GPIO_O[0])
    else $error("gpio0 not driven high");
  a_fwd_output: assert property (@(posedge CLK) disable iff (SRST)
    cfg_q[0][7:4] == `CODE_FWD_OUT |=> GPIO_O[1] == $past(FWD_GPIO[1]))
    else $error("gpio1 not following forward data");
  a_reg_low: assert property (@(posedge CLK) disable iff (SRST)
    reg_code[2] == `CODE_OUT_LOW ##1 $stable(reg_code[2]) |-> REG_GPIO_OE[2] && !REG_GPIO_O[2])
    else $error("register gpio7 not driven low");
  a_audio_override: assert property (@(posedge CLK) disable iff (SRST)
    reg_code[0] != 4'h0 |=> AUDIO_IN_BLOCK[0])
    else $error("gpio5 mode did not block audio input");
  a_write_both: assert property (@(posedge CLK) disable iff (SRST)
    REQ.we && REQ.addr == `ADDR_GPIO0_CFG && port_sel_q == 2'h3 |=>
    cfg_q[0][3:0] == $past(REQ.wdata[3:0]) && cfg_q[1][3:0] == $past(REQ.wdata[3:0]))
    else $error("dual port write missed a port");
  a_read_answer: assert property (@(posedge CLK) disable iff (SRST)
    REQ.re |=> RVALID)
    else $error("read not answered");
  a_status_high: assert property (@(posedge CLK) disable iff (SRST)
    REQ.re && REQ.addr == `ADDR_IN_STAT_HI |=> RDATA == {7'h00, $past(r_s2_q[3])})
    else $error("gpio8 status not returned");
  a_reg_fast1_mask: assert property (@(posedge CLK) disable iff (SRST)
    cc_cfg_q[2:0] == `MODE_FAST1 && $stable(cc_cfg_q) |=> BC_SAMPLE.gpio[3:1] == 3'b000)
    else $error("unused gpios sampled in one gpio mode");
endmodule

// >>> src/link_gpio_defines.svh
// register offsets, field positions, codes and timing counts for the link gpio block
`ifndef LINK_GPIO_DEFINES_SVH
`define LINK_GPIO_DEFINES_SVH
`define ADDR_GPIO0_CFG 8'h1D
`define ADDR_GPIO12_CFG 8'h1E
`define ADDR_GPIO3_CFG 8'h1F
`define ADDR_REG56_CFG 8'h20
`define ADDR_REG78_CFG 8'h21
`define ADDR_BC_RATE 8'h23
`define ADDR_PORT_SEL 8'h34
`define ADDR_CC_CFG 8'h43
`define ADDR_IN_STAT_LO 8'h6E
`define ADDR_IN_STAT_HI 8'h6F
`define CFG_RESET 8'h00
`define BC_RATE_RESET 8'h00
`define PORT_SEL_RESET 8'h01
`define CC_CFG_RESET 8'h00
`define CODE_OUT_LOW 4'h1
`define CODE_OUT_HIGH 4'h9
`define CODE_INPUT 4'h3
`define CODE_FWD_OUT 4'h5
`define BIT_BC_DIV_SEL 6
`define BIT_BC_HS_EN 4
`define MODE_NORMAL 3'h0
`define MODE_FAST4 3'h3
`define MODE_FAST2 3'h2
`define MODE_FAST1 3'h1
`define SAMPLES_NORMAL 4'h1
`define SAMPLES_FAST4 4'h6
`define SAMPLES_FAST2 4'hA
`define SAMPLES_FAST1 4'hF
`define DIV_SLOW 3'h4
`define DIV_MID 3'h2
`define DIV_FAST 3'h1
`endif

// >>> src/link_gpio_pkg.sv
// types shared by the link gpio block
package link_gpio_pkg;
  typedef enum logic [1:0] {RATE_5M, RATE_10M, RATE_20M} bc_rate_e;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic [3:0] gpio;
    logic intr_n;
    logic [3:0] count;
    logic valid;
  } bc_sample_s;
  typedef enum logic [1:0] {INT_IDLE, INT_SENT, INT_WAIT_RELEASE} int_state_e;
endpackage

// >>> verif/ser_model.sv
// serializer-side model: forward gpio data and interrupt reporting
`timescale 1ns/1ps
module ser_model (
  input wire logic clk,
  input wire logic srst,
  input wire logic bc_intr,
  input wire logic status_rd,
  output logic [3:0] fwd_gpio,
  output logic [3:0] fwd_d_gpio,
  output logic ser_int_n
);
  //==========
  // model
  logic [7:0] int_ctl_q;
  logic pend_q;
  logic intr_q;
  // codes 3 here pair with deserializer code 5; banks differ to expose bank mixups
  assign fwd_gpio = 4'hA;
  assign fwd_d_gpio = 4'h5;
  assign ser_int_n = !pend_q;
  always_ff @(posedge clk) begin
    if (srst) begin
      int_ctl_q <= 8'h21;
      pend_q <= 1'b0;
      intr_q <= 1'b0;
    end else begin
      intr_q <= bc_intr;
      if (status_rd) begin
        pend_q <= 1'b0;
      end else if (bc_intr && !intr_q && int_ctl_q[5] && int_ctl_q[0]) begin
        pend_q <= 1'b1;
      end
    end
  end
endmodule

// >>> verif/tb.sv
// self-checking bench for the link gpio block
`timescale 1ns/1ps
`include "link_gpio_defines.svh"
module tb;
  //==========
  // signals
  logic CLK = 1'b0;
  logic SRST = 1'b1;
  link_gpio_pkg::reg_req_s REQ = '0;
  logic TWO_LANE = 1'b1;
  logic STRAP = 1'b0;
  logic LD = 1'b0;
  logic LDV = 1'b0;
  logic INT_N = 1'b1;
  logic SRD = 1'b0;
  logic [3:0] GI = 4'h0;
  logic [3:0] DGI = 4'h0;
  logic [3:0] RGI = 4'h0;
  logic [7:0] RDATA;
  logic RVALID, MODE18, BC_INTR, SER_INT_N;
  logic [3:0] FW, FWD, GO, GOE, DGO, DGOE, RGO, RGOE, AUD;
  link_gpio_pkg::bc_sample_s BS;
  logic [2:0] DIV;
  link_gpio_pkg::bc_rate_e RATE;
  int errors = 0;
  int checks_done = 0;
  link_gpio_and_backchannel_ctrl i_dut (.CLK(CLK), .SRST(SRST), .REQ(REQ), .RDATA(RDATA), .RVALID(RVALID),
    .TWO_LANE(TWO_LANE), .STRAP_HS(STRAP), .MODE18_LOAD(LD), .MODE18_VALUE(LDV), .MODE18(MODE18),
    .REMOTE_INTERRUPT_INPUT_N(INT_N), .BC_INTR(BC_INTR), .FWD_GPIO(FW), .FWD_D_GPIO(FWD), .GPIO_I(GI),
    .GPIO_O(GO), .GPIO_OE(GOE), .D_GPIO_I(DGI), .D_GPIO_O(DGO), .D_GPIO_OE(DGOE), .REG_GPIO_I(RGI),
    .REG_GPIO_O(RGO), .REG_GPIO_OE(RGOE), .AUDIO_IN_BLOCK(AUD), .BC_SAMPLE(BS), .BC_DIVIDER(DIV), .BC_RATE(RATE));
  ser_model i_ser (.clk(CLK), .srst(SRST), .bc_intr(BC_INTR), .status_rd(SRD), .fwd_gpio(FW),
    .fwd_d_gpio(FWD), .ser_int_n(SER_INT_N));
  //==========
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK) REQ <= {1'b1, 1'b0, a, d};
    @(posedge CLK) REQ <= '0;
  endtask
  // read answer stands one cycle only, so it is taken right after the edge
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge CLK) REQ <= {1'b0, 1'b1, a, 8'h00};
    @(posedge CLK) REQ <= '0;
    #1;
    chk({7'h00, RVALID}, 8'h01);
    chk(RDATA, e);
  endtask
  task automatic wait_intr(input logic v);
    int n;
    n = 0;
    while (BC_INTR !== v && n < 10) begin
      cyc(1);
      n++;
    end
    chk({7'h00, BC_INTR}, {7'h00, v});
  endtask
  task automatic summarize();
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  //==========
  // scenarios
  task automatic t_rate();
    logic [7:0] v [4];
    v = '{8'h40, 8'h50, 8'h10, 8'h00};
    chk(8'(DIV), 8'(`DIV_SLOW));
    rdc(`ADDR_PORT_SEL, `PORT_SEL_RESET);
    rdc(`ADDR_BC_RATE, `BC_RATE_RESET);
    rdc(8'h55, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_BC_RATE, v[i]);
      cyc(2);
      chk(8'(DIV), v[i][4] ? 8'h01 : (v[i][6] ? 8'h02 : 8'h04));
      chk(8'(RATE), 8'(v[i][4] ? link_gpio_pkg::RATE_20M : v[i][6] ? link_gpio_pkg::RATE_10M
        : link_gpio_pkg::RATE_5M));
      rdc(`ADDR_BC_RATE, v[i]);
    end
  endtask
  task automatic t_pins();
    @(posedge CLK);
    GI <= 4'hC;
    DGI <= 4'h3;
    wr(`ADDR_PORT_SEL, 8'h03);
    wr(`ADDR_GPIO0_CFG, 8'h01);
    wr(`ADDR_GPIO12_CFG, 8'h95);
    wr(`ADDR_GPIO3_CFG, 8'h03);
    cyc(4);
    chk({GOE, GO & GOE}, 8'h76);
    chk({DGOE, DGO & DGOE}, 8'h74);
    chk(8'(BS.gpio), 8'h08);
    rdc(`ADDR_IN_STAT_LO, 8'h03);
    wr(`ADDR_PORT_SEL, 8'h01);
    wr(`ADDR_GPIO0_CFG, 8'h09);
    cyc(2);
    chk({GO[0], DGO[0]}, 8'h02);
    rdc(`ADDR_GPIO0_CFG, 8'h09);
    wr(`ADDR_PORT_SEL, 8'h03);
    rdc(`ADDR_GPIO0_CFG, 8'h01);
    wr(`ADDR_PORT_SEL, 8'h01);
    TWO_LANE <= 1'b0;
    cyc(3);
    chk(8'(DGOE), 8'h00);
    TWO_LANE <= 1'b1;
  endtask
  task automatic t_reg();
    @(posedge CLK);
    RGI <= 4'hA;
    wr(`ADDR_REG56_CFG, 8'h39);
    wr(`ADDR_REG78_CFG, 8'h31);
    cyc(4);
    chk({RGOE, RGO & RGOE}, 8'h51);
    chk(8'(AUD), 8'h0F);
    rdc(`ADDR_IN_STAT_LO, 8'h4C);
    rdc(`ADDR_IN_STAT_HI, 8'h01);
  endtask
  task automatic t_intr();
    @(posedge CLK) INT_N <= 1'b0;
    wait_intr(1'b1);
    chk({7'h00, BS.intr_n}, 8'h00);
    cyc(1);
    chk({7'h00, SER_INT_N}, 8'h00);
    @(posedge CLK) SRD <= 1'b1;
    @(posedge CLK) SRD <= 1'b0;
    cyc(1);
    chk({7'h00, SER_INT_N}, 8'h01);
    cyc(6);
    chk({7'h00, BC_INTR}, 8'h01);
    @(posedge CLK) INT_N <= 1'b1;
    wait_intr(1'b0);
    @(posedge CLK) INT_N <= 1'b0;
    wait_intr(1'b1);
    @(posedge CLK) INT_N <= 1'b1;
    cyc(10);
  endtask
  task automatic t_mode();
    logic [2:0] m [4];
    logic [3:0] n [4];
    logic [3:0] mx;
    m = '{`MODE_NORMAL, `MODE_FAST4, `MODE_FAST2, `MODE_FAST1};
    n = '{4'd1, 4'd6, 4'd10, 4'd15};
    for (int i = 0; i < 4; i++) begin
      wr(`ADDR_CC_CFG, {5'h00, m[i]});
      cyc(20);
      mx = 4'h0;
      repeat (32) begin
        if (BS.valid === 1'b1 && BS.count > mx) begin
          mx = BS.count;
        end
        cyc(1);
      end
      chk(8'(mx), 8'(n[i] - 4'd1));
      chk(8'(BS.gpio), (i < 2) ? 8'h08 : 8'h00);
      chk({7'h00, BS.valid}, 8'h01);
    end
  endtask
  // mid-run reset with the strap set: high speed must come up by itself
  task automatic t_strap();
    @(posedge CLK) SRST <= 1'b1;
    STRAP <= 1'b1;
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    cyc(2);
    chk(8'(DIV), 8'(`DIV_FAST));
    chk({7'h00, MODE18}, 8'h00);
    rdc(`ADDR_BC_RATE, 8'(1 << `BIT_BC_HS_EN));
    rdc(`ADDR_PORT_SEL, `PORT_SEL_RESET);
  endtask
  //==========
  // run
  initial begin
    forever #50 CLK = ~CLK;
  end
  initial begin
    #2000000;
    errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge CLK);
    SRST <= 1'b0;
    cyc(2);
    t_rate();
    t_pins();
    t_reg();
    t_intr();
    t_mode();
    @(posedge CLK) LDV <= 1'b1;
    LD <= 1'b1;
    @(posedge CLK) LD <= 1'b0;
    cyc(2);
    chk({7'h00, MODE18}, 8'h01);
    t_strap();
    summarize();
  end
endmodule
